// ==== rtl/rcc_pkg.sv ====
// Purpose: shared constants for the calendar clock with alarm
// Assumes: 10 MHz reference clock, registers reached over APB
// Notes: register index times four gives the byte address
package rcc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned SECOND_NS = 1000000000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
   // half periods of the 16 Hz output in one second
   localparam int unsigned SUB16_DIV = 32;
   // ---------------------------------------------------------------
   // register indexes
   // ---------------------------------------------------------------
   localparam logic [3:0] IX_SEC = 4'h0;
   localparam logic [3:0] IX_MIN = 4'h1;
   localparam logic [3:0] IX_HOUR = 4'h2;
   localparam logic [3:0] IX_WDAY = 4'h4;
   localparam logic [3:0] IX_DATE = 4'h5;
   localparam logic [3:0] IX_MONTH = 4'h6;
   localparam logic [3:0] IX_YEAR = 4'h7;
   localparam logic [3:0] IX_PAGE = 4'h8;
   localparam logic [3:0] IX_REST = 4'hc;
   localparam logic [3:0] IX_RSVD = 4'hd;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int PG_PAGE = 0;
   localparam int PG_ALM_EN = 2;
   localparam int PG_CLK_EN = 3;
   localparam int PG_ADJ = 4;
   localparam int PG_IRQ_EN = 7;
   localparam int RS_ALM_CLR = 4;
   localparam int RS_CLK_CLR = 5;
   localparam int RS_16_OFF = 6;
   localparam int RS_1_OFF = 7;
   localparam int HR_PM = 5;
   // ---------------------------------------------------------------
   // values after reset
   // ---------------------------------------------------------------
   localparam logic PAGE_RST = 1'b0;
   localparam logic ADJ_RST = 1'b0;
   localparam logic IRQ_EN_RST = 1'b0;
   localparam logic CLK_EN_RST = 1'b0;
   localparam logic ALM_EN_RST = 1'b0;
   localparam logic OFF16_RST = 1'b1;
   localparam logic OFF1_RST = 1'b1;
   // ---------------------------------------------------------------
   // bcd limits
   // ---------------------------------------------------------------
   localparam logic [7:0] SEC_MAX = 8'h59;
   localparam logic [7:0] MIN_MAX = 8'h59;
   localparam logic [7:0] HR24_MAX = 8'h23;
   localparam logic [7:0] HR12_MAX = 8'h11;
   localparam logic [7:0] WDAY_MAX = 8'h06;
   localparam logic [7:0] MONTH_MAX = 8'h12;
   localparam logic [7:0] YEAR_MAX = 8'h99;
   localparam logic [7:0] ADJ_HALF = 8'h30;
   localparam logic [7:0] FEB = 8'h02;
endpackage

// ==== rtl/rcc_tick_gen.sv ====
// Purpose: one second tick and square waves from the reference clock
// Assumes: run and clear are synchronous levels
// Notes: clear restarts the second so a fresh setting starts whole
`timescale 1ns/100ps
module rcc_tick_gen #(
   parameter int unsigned SEC_CYCLES = rcc_pkg::SEC_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic run_in,
   input wire logic clear_in,
   // timing outputs
   output logic tick_out,
   output logic sq1_out,
   output logic sq16_out
);
   localparam int CW = $clog2(SEC_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(SEC_CYCLES - 1);
   localparam logic [CW-1:0] HALF = CW'(SEC_CYCLES / 2);
   localparam logic [CW-1:0] SUB_LAST = CW'(SEC_CYCLES / rcc_pkg::SUB16_DIV - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic [CW-1:0] sub;
      logic sq16;
      logic tick;
   } rcc_tick_st_t;

   rcc_tick_st_t st_reg;
   rcc_tick_st_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (clear_in) begin
         st_next.cnt = '0;
         st_next.sub = '0;
         st_next.sq16 = 1'b0;
      end else if (run_in) begin
         if (st_reg.cnt == LAST) begin
            st_next.cnt = '0;
            st_next.sub = '0;
            st_next.sq16 = 1'b0;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
            if (st_reg.sub == SUB_LAST) begin
               st_next.sub = '0;
               st_next.sq16 = ~st_reg.sq16;
            end else begin
               st_next.sub = st_reg.sub + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_out = st_reg.tick;
   assign sq1_out = (st_reg.cnt < HALF);
   assign sq16_out = st_reg.sq16;
endmodule

// ==== rtl/rcc_top.sv ====
// Purpose: calendar clock with alarm behind an APB register page pair
// Assumes: byte address is register index times four
// Notes: time counts keep their contents through reset
//
// Summary of operation
// - keep hours, minutes, seconds and month, weekday, date, leap state
// - software picks 12-hour with am/pm or 24-hour counting
// - adjust request rounds seconds to nearest minute, up to thirty seconds
// - two year digits only, 99 rolls to 00
// - every fourth year is leap, no century exceptions
// - page bit steers shared addresses to clock or alarm page
// - seconds exist only on the clock page
// - alarm page month address holds the 24/12 select bit
// - alarm page year address holds two-bit leap state
// - unused addresses read zero and ignore writes
// - reset sets page, adjust, enable and reset-register bits; counts kept
// - clock page reads return a snapshot of the current count
// - alarm page reads return the current alarm values
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module rcc_top #(
   parameter int unsigned SEC_CYCLES = rcc_pkg::SEC_CYCLES
) (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_IN,
   // apb slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [5:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // alarm
   output logic ALARM_OUT,
   output logic IRQ_OUT
);
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] date;
      logic [7:0] month;
      logic [7:0] year;
      logic [7:0] a_min;
      logic [7:0] a_hour;
      logic [7:0] a_wday;
      logic [7:0] a_date;
      logic mode24;
      logic [1:0] leap;
      logic page;
      logic adjust;
      logic irq_en;
      logic clk_en;
      logic alm_en;
      logic off16;
      logic off1;
      logic hit;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic alarm;
      logic irq;
   } rcc_state_t;

   rcc_state_t st;
   rcc_state_t nx;

   // ---------------------------------------------------------------
   // bcd helpers
   // ---------------------------------------------------------------
   function automatic logic [8:0] bcd_step(input logic [7:0] v,
         input logic [7:0] lo, input logic [7:0] hi);
      if (v == hi) begin
         return {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         return {1'b0, v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // month length; leap state zero marks a year divisible by four
   function automatic logic [7:0] month_len(input logic [7:0] m,
         input logic [1:0] lp);
      if (m == rcc_pkg::FEB) begin
         return (lp == 2'd0) ? 8'h29 : 8'h28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         return 8'h30;
      end else begin
         return 8'h31;
      end
   endfunction

   // ---------------------------------------------------------------
   // tick source
   // ---------------------------------------------------------------
   logic tick;
   logic sq1;
   logic sq16;
   logic clk_clear;

   rcc_tick_gen #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_tick (
      .clk_in(REF_CLK_IN),
      .rst_in(RST_IN),
      .run_in(st.clk_en),
      .clear_in(clk_clear),
      .tick_out(tick),
      .sq1_out(sq1),
      .sq16_out(sq16)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [3:0] idx;
   logic [7:0] wd;
   logic [7:0] rd;
   logic cap;
   logic wr;
   logic c_min;
   logic c_hr;
   logic c_day;
   logic c_mon;
   logic c_yr;
   logic hit_set;
   logic [8:0] t9;

   assign idx = PADDR_IN[5:2];
   assign wd = PWDATA_IN[7:0];
   // one wait state: capture in the first access cycle, finish in the next
   assign cap = PSEL_IN & PENABLE_IN & ~st.ready;
   assign wr = PSEL_IN & PENABLE_IN & st.ready & PWRITE_IN;
   assign clk_clear = wr & (idx == rcc_pkg::IX_REST) & wd[rcc_pkg::RS_CLK_CLR];

   always_comb begin
      nx = st;
      c_min = 1'b0;
      c_hr = 1'b0;
      c_day = 1'b0;
      c_mon = 1'b0;
      c_yr = 1'b0;
      hit_set = 1'b0;
      rd = 8'h00;
      t9 = 9'h000;
      // ---------------------------------------------------------------
      // time keeping
      // ---------------------------------------------------------------
      if (tick) begin
         if (st.adjust) begin
            nx.sec = 8'h00;
            c_min = (st.sec >= rcc_pkg::ADJ_HALF);
            nx.adjust = 1'b0;
         end else begin
            {c_min, nx.sec} = bcd_step(st.sec, 8'h00, rcc_pkg::SEC_MAX);
         end
      end
      if (c_min) begin
         {c_hr, nx.min} = bcd_step(st.min, 8'h00, rcc_pkg::MIN_MAX);
      end
      if (c_hr) begin
         if (st.mode24) begin
            {c_day, nx.hour} = bcd_step(st.hour, 8'h00, rcc_pkg::HR24_MAX);
         end else begin
            // low five bits count 0..11, the pm bit flips on each wrap
            t9 = bcd_step({3'b000, st.hour[4:0]}, 8'h00, rcc_pkg::HR12_MAX);
            nx.hour = {2'b00, st.hour[rcc_pkg::HR_PM] ^ t9[8], t9[4:0]};
            c_day = t9[8] & st.hour[rcc_pkg::HR_PM];
         end
      end
      if (c_day) begin
         t9 = bcd_step(st.wday, 8'h00, rcc_pkg::WDAY_MAX);
         nx.wday = t9[7:0];
         {c_mon, nx.date} = bcd_step(st.date, 8'h01, month_len(st.month, st.leap));
      end
      if (c_mon) begin
         {c_yr, nx.month} = bcd_step(st.month, 8'h01, rcc_pkg::MONTH_MAX);
      end
      if (c_yr) begin
         t9 = bcd_step(st.year, 8'h00, rcc_pkg::YEAR_MAX);
         nx.year = t9[7:0];
         nx.leap = st.leap + 2'd1;
      end
      // alarm compares on each new minute
      hit_set = st.alm_en & c_min & (nx.min == st.a_min) & (nx.hour == st.a_hour)
         & (nx.wday == st.a_wday) & (nx.date == st.a_date);
      // ---------------------------------------------------------------
      // register writes
      // ---------------------------------------------------------------
      if (wr) begin
         unique case (idx)
            rcc_pkg::IX_SEC: begin
               if (!st.page) begin
                  nx.sec = {1'b0, wd[6:0]};
               end
            end
            rcc_pkg::IX_MIN: begin
               if (st.page) begin
                  nx.a_min = {1'b0, wd[6:0]};
               end else begin
                  nx.min = {1'b0, wd[6:0]};
               end
            end
            rcc_pkg::IX_HOUR: begin
               if (st.page) begin
                  nx.a_hour = {2'b00, wd[5:0]};
               end else begin
                  nx.hour = {2'b00, wd[5:0]};
               end
            end
            rcc_pkg::IX_WDAY: begin
               if (st.page) begin
                  nx.a_wday = {5'h00, wd[2:0]};
               end else begin
                  nx.wday = {5'h00, wd[2:0]};
               end
            end
            rcc_pkg::IX_DATE: begin
               if (st.page) begin
                  nx.a_date = {2'b00, wd[5:0]};
               end else begin
                  nx.date = {2'b00, wd[5:0]};
               end
            end
            rcc_pkg::IX_MONTH: begin
               if (st.page) begin
                  nx.mode24 = wd[0];
               end else begin
                  nx.month = {3'b000, wd[4:0]};
               end
            end
            rcc_pkg::IX_YEAR: begin
               if (st.page) begin
                  nx.leap = wd[1:0];
               end else begin
                  nx.year = wd;
               end
            end
            rcc_pkg::IX_PAGE: begin
               nx.page = wd[rcc_pkg::PG_PAGE];
               nx.alm_en = wd[rcc_pkg::PG_ALM_EN];
               nx.clk_en = wd[rcc_pkg::PG_CLK_EN];
               nx.adjust = wd[rcc_pkg::PG_ADJ];
               nx.irq_en = wd[rcc_pkg::PG_IRQ_EN];
            end
            rcc_pkg::IX_REST: begin
               nx.off16 = wd[rcc_pkg::RS_16_OFF];
               nx.off1 = wd[rcc_pkg::RS_1_OFF];
               if (wd[rcc_pkg::RS_ALM_CLR]) begin
                  nx.hit = 1'b0;
               end
            end
            default: begin
               // unused and reserved addresses change nothing
            end
         endcase
      end
      // a match in the clearing cycle still lands
      nx.hit = nx.hit | hit_set;
      // ---------------------------------------------------------------
      // register reads, captured one cycle before ready
      // ---------------------------------------------------------------
      unique case (idx)
         rcc_pkg::IX_SEC: rd = st.page ? 8'h00 : st.sec;
         rcc_pkg::IX_MIN: rd = st.page ? st.a_min : st.min;
         rcc_pkg::IX_HOUR: rd = st.page ? st.a_hour : st.hour;
         rcc_pkg::IX_WDAY: rd = st.page ? st.a_wday : st.wday;
         rcc_pkg::IX_DATE: rd = st.page ? st.a_date : st.date;
         rcc_pkg::IX_MONTH: rd = st.page ? {7'h00, st.mode24} : st.month;
         rcc_pkg::IX_YEAR: rd = st.page ? {6'h00, st.leap} : st.year;
         rcc_pkg::IX_PAGE: rd = {st.irq_en, 2'b00, st.adjust, st.clk_en,
            st.alm_en, 1'b0, st.page};
         rcc_pkg::IX_REST: rd = {st.off1, st.off16, 6'h00};
         default: rd = 8'h00;
      endcase
      nx.ready = cap;
      if (cap) begin
         nx.rdata = {24'h000000, rd};
         nx.slverr = (idx == rcc_pkg::IX_RSVD);
      end
      // ---------------------------------------------------------------
      // outputs
      // ---------------------------------------------------------------
      nx.alarm = nx.hit | (~st.off1 & sq1) | (~st.off16 & sq16);
      nx.irq = nx.hit & st.irq_en;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // counts have no reset so a reset keeps the running time
   always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         st.page <= rcc_pkg::PAGE_RST;
         st.adjust <= rcc_pkg::ADJ_RST;
         st.irq_en <= rcc_pkg::IRQ_EN_RST;
         st.clk_en <= rcc_pkg::CLK_EN_RST;
         st.alm_en <= rcc_pkg::ALM_EN_RST;
         st.off16 <= rcc_pkg::OFF16_RST;
         st.off1 <= rcc_pkg::OFF1_RST;
         st.hit <= 1'b0;
         st.rdata <= 32'h00000000;
         st.ready <= 1'b0;
         st.slverr <= 1'b0;
         st.alarm <= 1'b0;
         st.irq <= 1'b0;
      end else begin
         st <= nx;
      end
   end

   assign PRDATA_OUT = st.rdata;
   assign PREADY_OUT = st.ready;
   assign PSLVERR_OUT = st.slverr;
   assign ALARM_OUT = st.alarm;
   assign IRQ_OUT = st.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sec_carry_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (tick && !st.adjust && st.sec == 8'h59 && !wr)
      |=> (st.sec == 8'h00 && st.min != $past(st.min)))
      else $error("seconds did not carry into minutes");
   year_wrap_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (c_yr && st.year == 8'h99 && !wr) |=> st.year == 8'h00)
      else $error("year did not roll from 99 to 00");
   leap_feb_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (c_day && st.month == 8'h02 && st.date == 8'h28 && st.leap == 2'd0 && !wr)
      |=> st.date == 8'h29)
      else $error("leap february lost its 29th");
   hour_twelve_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (c_hr && !st.mode24 && st.hour == 8'h11 && !wr) |=> st.hour == 8'h20)
      else $error("12-hour count did not turn to pm zero");
   adjust_round_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (tick && st.adjust && st.sec >= 8'h30 && !wr)
      |=> (st.sec == 8'h00 && !st.adjust && st.min != $past(st.min)))
      else $error("adjust did not round up to the next minute");
   unused_zero_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (cap && (idx == 4'h3 || idx == 4'h9 || idx == 4'ha || idx == 4'hb
      || idx == 4'he || idx == 4'hf)) |=> (PREADY_OUT && PRDATA_OUT == 32'h0))
      else $error("unused address did not read zero");
   sec_alarm_page_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (cap && st.page && idx == 4'h0) |=> PRDATA_OUT == 32'h0)
      else $error("seconds visible on alarm page");
   snapshot_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (cap && !st.page && idx == 4'h1) |=> PRDATA_OUT == {24'h0, $past(st.min)})
      else $error("minute read is not the captured count");
   alarm_read_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (cap && st.page && idx == 4'h2) |=> PRDATA_OUT == {24'h0, $past(st.a_hour)})
      else $error("alarm hour read is wrong");
   page_sel_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (wr && idx == 4'h8) |=> st.page == $past(PWDATA_IN[0]))
      else $error("page bit not taken from write");
   irq_gate_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      (!st.irq_en |=> !IRQ_OUT) and (hit_set && st.irq_en |=> IRQ_OUT))
      else $error("interrupt not gated by enable");
   reset_init_a: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
      $fell(RST_IN) |-> (!st.page && !st.adjust && !st.irq_en && st.off1 && st.off16))
      else $error("control bits not initialised by reset");
endmodule

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the calendar clock with alarm
// Assumes: one wait state on apb, SEC_CYCLES shortened to 128
// Notes: counts are loaded with the clock stopped, then one tick is let through
`timescale 1ns/100ps
module tb_top;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int unsigned SC = 128;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [5:0] padr = 6'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic prdy;
   logic perr;
   logic alarm;
   logic irq;
   logic [31:0] rv;
   int miscompares = 0;
   int comparisons = 0;

   always #50 clk = ~clk;

   rcc_top #(.SEC_CYCLES(SC)) rcc_top_inst (
      .REF_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
      .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .ALARM_OUT(alarm), .IRQ_OUT(irq)
   );

   // ---------------------------------------------------------------
   // reporting
   // ---------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_pin(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   // ---------------------------------------------------------------
   // apb master: request held until pready is seen at a rising edge
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [3:0] ix, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= {ix, 2'b00};
      pwd <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 10);
      rv = prd;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n >= 10) begin
         miscompares++;
         $display("BAD pready expected 1 seen %b", prdy);
      end
   endtask

   task automatic wr(input logic [3:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d);
   endtask

   task automatic rd_chk(input string nm, input logic [3:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      chk_word(nm, {24'h0, e}, rv);
   endtask

   // read twice, judge the second read, then check that both reads agree
   task automatic rd2_chk(input string nm, input logic [3:0] ix, input logic [7:0] e);
      logic [31:0] rv1;
      apb(1'b0, ix, 8'h00);
      rv1 = rv;
      rd_chk(nm, ix, e);
      chk_word({nm, "_pair"}, rv1, rv);
   endtask

   // load the counts, 24/12 bit and leap state with the clock stopped, restart the second, run one tick
   task automatic set_cal(input logic [7:0] s, m, h, w, d, mo, y, m24, lp, ctl);
      wr(rcc_pkg::IX_PAGE, 8'h00);
      wr(rcc_pkg::IX_SEC, s); // callers pass only 00..59
      wr(rcc_pkg::IX_MIN, m);
      wr(rcc_pkg::IX_HOUR, h);
      wr(rcc_pkg::IX_WDAY, w);
      wr(rcc_pkg::IX_DATE, d);
      wr(rcc_pkg::IX_MONTH, mo);
      wr(rcc_pkg::IX_YEAR, y);
      wr(rcc_pkg::IX_PAGE, 8'h01);
      wr(rcc_pkg::IX_MONTH, m24);
      wr(rcc_pkg::IX_YEAR, lp);
      wr(rcc_pkg::IX_PAGE, 8'h00);
      wr(rcc_pkg::IX_REST, 8'he7);
      wr(rcc_pkg::IX_PAGE, ctl);
      repeat (SC + 6) @(posedge clk);
   endtask

   // every field read twice; all pairs finish before the next tick
   task automatic chk_time(input logic [7:0] s, m, h, w, d, mo, y);
      rd2_chk("sec", rcc_pkg::IX_SEC, s);
      rd2_chk("min", rcc_pkg::IX_MIN, m);
      rd2_chk("hour", rcc_pkg::IX_HOUR, h);
      rd2_chk("wday", rcc_pkg::IX_WDAY, w);
      rd2_chk("date", rcc_pkg::IX_DATE, d);
      rd2_chk("month", rcc_pkg::IX_MONTH, mo);
      rd2_chk("year", rcc_pkg::IX_YEAR, y);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd_chk("page_rst", rcc_pkg::IX_PAGE, 8'h00);
      rd_chk("rest_rst", rcc_pkg::IX_REST, 8'hc0);
      wr(rcc_pkg::IX_MIN, 8'h37);
      wr(rcc_pkg::IX_PAGE, 8'h84);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_chk("page_rst2", rcc_pkg::IX_PAGE, 8'h00);
      rd_chk("min_kept", rcc_pkg::IX_MIN, 8'h37);
      chk_pin("irq_rst", 1'b0, irq);
   endtask

   task automatic t_unused();
      logic [3:0] ixs [6] = '{4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf}; // reserved d skipped
      foreach (ixs[i]) begin
         wr(ixs[i], 8'hff);
         rd_chk("unused", ixs[i], 8'h00);
         chk_pin("slverr", 1'b0, perr);
      end
   endtask

   task automatic t_year_end();
      set_cal(8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99, 8'h01, 8'h03, 8'h08);
      wr(rcc_pkg::IX_PAGE, 8'h00);
      chk_time(8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00);
      wr(rcc_pkg::IX_PAGE, 8'h01);
      rd2_chk("leap", rcc_pkg::IX_YEAR, 8'h00);
      rd_chk("mode24", rcc_pkg::IX_MONTH, 8'h01);
      wr(rcc_pkg::IX_SEC, 8'h12);
      rd_chk("alm_sec", rcc_pkg::IX_SEC, 8'h00);
      wr(rcc_pkg::IX_PAGE, 8'h00);
      rd_chk("sec_kept", rcc_pkg::IX_SEC, 8'h00);
   endtask

   task automatic t_feb();
      set_cal(8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h24, 8'h01, 8'h00, 8'h08);
      chk_time(8'h00, 8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h24);
      set_cal(8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h25, 8'h01, 8'h01, 8'h08);
      chk_time(8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h25);
   endtask

   task automatic t_12h();
      set_cal(8'h59, 8'h59, 8'h11, 8'h01, 8'h05, 8'h05, 8'h10, 8'h00, 8'h01, 8'h08);
      chk_time(8'h00, 8'h00, 8'h20, 8'h01, 8'h05, 8'h05, 8'h10);
      set_cal(8'h59, 8'h59, 8'h31, 8'h01, 8'h05, 8'h05, 8'h10, 8'h00, 8'h01, 8'h08);
      chk_time(8'h00, 8'h00, 8'h00, 8'h02, 8'h06, 8'h05, 8'h10);
   endtask

   task automatic t_adjust();
      set_cal(8'h45, 8'h20, 8'h08, 8'h01, 8'h05, 8'h05, 8'h10, 8'h01, 8'h01, 8'h18);
      chk_time(8'h00, 8'h21, 8'h08, 8'h01, 8'h05, 8'h05, 8'h10);
      rd_chk("adj_clear", rcc_pkg::IX_PAGE, 8'h08);
      set_cal(8'h10, 8'h20, 8'h08, 8'h01, 8'h05, 8'h05, 8'h10, 8'h01, 8'h01, 8'h18);
      chk_time(8'h00, 8'h20, 8'h08, 8'h01, 8'h05, 8'h05, 8'h10);
   endtask

   task automatic t_alarm();
      int n;
      logic [7:0] codes [2] = '{8'h47, 8'h87};
      wr(rcc_pkg::IX_PAGE, 8'h01);
      wr(rcc_pkg::IX_MIN, 8'h15);
      wr(rcc_pkg::IX_HOUR, 8'h05);
      wr(rcc_pkg::IX_WDAY, 8'h02);
      wr(rcc_pkg::IX_DATE, 8'h10);
      rd_chk("alm_min", rcc_pkg::IX_MIN, 8'h15);
      rd_chk("alm_hour", rcc_pkg::IX_HOUR, 8'h05);
      set_cal(8'h59, 8'h14, 8'h05, 8'h02, 8'h10, 8'h05, 8'h10, 8'h01, 8'h01, 8'h8c);
      chk_pin("alarm_set", 1'b1, alarm);
      chk_pin("irq_set", 1'b1, irq);
      wr(rcc_pkg::IX_PAGE, 8'h0c);
      repeat (2) @(posedge clk);
      chk_pin("irq_masked", 1'b0, irq);
      chk_pin("alarm_held", 1'b1, alarm);
      wr(rcc_pkg::IX_REST, 8'hd7);
      repeat (2) @(posedge clk);
      chk_pin("alarm_clr", 1'b0, alarm);
      // 1 Hz then 16 Hz square on the alarm pin: half of one second high
      foreach (codes[k]) begin
         wr(rcc_pkg::IX_REST, codes[k]);
         @(posedge clk);
         n = 0;
         repeat (SC) begin
            @(posedge clk);
            n += (alarm === 1'b1);
         end
         chk_word("square_high", SC / 2, n);
      end
      wr(rcc_pkg::IX_PAGE, 8'h00);
   endtask

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_unused();
      t_year_end();
      t_feb();
      t_12h();
      t_adjust();
      t_alarm();
      print_verdict();
   end

   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      $display("BAD watchdog expected finish seen hang");
      print_verdict();
   end
endmodule
